// ===== rtl/rcc_pkg.sv
// Constants for the read-channel control-input block.
// Assumes a byte-addressed register port with 8-bit data.
package rcc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] COR_ADDR    = 8'h00;
  localparam logic [7:0] CTR_ADDR    = 8'h01;
  localparam logic [7:0] PDR_ADDR    = 8'h02;
  localparam logic [7:0] STATUS_ADDR = 8'h03;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int COR_WGP_BIT    = 0;
  localparam int COR_NIBBLE_BIT = 1;
  localparam int COR_BYPASS_BIT = 3;
  localparam int CTR_VIT_BIT    = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] COR_RESET = 8'h01;
  localparam logic [7:0] CTR_RESET = 8'h00;
  localparam logic [7:0] PDR_RESET = 8'h00;
  localparam logic       PIN_IDLE  = 1'b1;
  // ----------------------------------------------------------------
  // Read reference clock source states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RC_TBG    = 4'b0001,
    RC_WAIT   = 4'b0010,
    RC_SWITCH = 4'b0100,
    RC_VCO    = 4'b1000
  } rcc_rclk_t;
endpackage

// ===== rtl/rcc_core.sv
// Control-input decoding for a sampled-data disk read channel.
// Assumes all pins are sampled on clk and that clock pins are slow
// enough to be seen as levels at 200 MHz.
// Summary of operation
// - Low-impedance input high lowers AGC impedance; low keeps it high.
// - Fast-recovery input high runs the AGC charge pump in fast decay.
// - Power-down input low shuts sections, AGC, equalizer and modes; integrator selects and muxes stay live.
// - With power-down high, power register bits switch sections off.
// - AGC hold input low stops the charge pump; high lets loop run.
// - Equalizer freeze high holds tap weights until it returns low.
// - Bypass bit 3 feeds reference frequency to the separator.
// - Write clock rising edge captures NRZ data at selected width.
// - Read gate rise selects read data reference and starts sequences.
// - Read gate low locks separator PLL to time base output.
// - Write mode follows write gate at level set by polarity bit.
// - Servo integrator used when servo gate 1, data integrator when 0.
// - Viterbi test input reaches back end only when test bit set.
// - Direct-write enable low routes direct-write inputs to write flop.
// - Unconnected gate and control inputs other than power-down act as logic high.
// - Read clock stays on time base until sync, then glitch-free to VCO.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module rcc_core #(
  parameter int NRZ_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             low_impedance_ctl,
  input  wire logic             fast_recovery_ctl,
  input  wire logic             sleep_request_n,
  input  wire logic             agc_hold_n,
  input  wire logic             equalizer_freeze,
  input  wire logic             read_gate,
  input  wire logic             write_gate,
  input  wire logic             servo_gate,
  input  wire logic             direct_write2_enable_n,
  input  wire logic             write_clock,
  input  wire logic [NRZ_W-1:0] nrz_write_in,
  input  wire logic             reference_frequency_in,
  input  wire logic             separator_vco_in,
  input  wire logic             time_base_in,
  input  wire logic             sync_field_found,
  input  wire logic             viterbi_test_data_in,
  input  wire logic             detector_data_in,
  input  wire logic             direct_write_in,
  input  wire logic             encoder_write_bit,
  output logic                  low_impedance_on,
  output logic                  fast_decay_on,
  output logic                  sleep_active,
  output logic      [7:0]       section_power_on,
  output logic                  agc_pump_on,
  output logic                  equalizer_adapt_on,
  output logic                  separator_clock_bypass,
  output logic                  separator_clk_out,
  output logic                  pll_ref_read_data,
  output logic                  read_mode,
  output logic                  read_start,
  output logic                  write_mode,
  output logic                  servo_mode,
  output logic                  servo_agc_integrator,
  output logic                  data_agc_integrator,
  output logic                  backend_data_out,
  output logic                  write_flop_in,
  output logic                  rclk_out,
  output logic      [NRZ_W-1:0] write_word,
  output logic                  write_word_valid
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Preset to the idle high level so an undriven pin reads high.
  localparam int NS = 9;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  assign pin_raw = {write_clock, direct_write2_enable_n, servo_gate,
                    write_gate, read_gate, equalizer_freeze, agc_hold_n,
                    fast_recovery_ctl, low_impedance_ctl};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= {NS{rcc_pkg::PIN_IDLE}};
      sync2_q <= {NS{rcc_pkg::PIN_IDLE}};
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end
  logic lz_s, fr_s, hold_s, eq_s, rg_s, wg_s, sg_s, dw_s, wclk_s;
  assign {wclk_s, dw_s, sg_s, wg_s, rg_s, eq_s, hold_s, fr_s, lz_s} = sync2_q;

  // Power-down has no idle level: it is sampled low so that an early
  // reset keeps the chip asleep until a real high arrives.
  logic pd1_q;
  logic pd2_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pd1_q <= 1'b0;
      pd2_q <= 1'b0;
    end else begin
      pd1_q <= sleep_request_n;
      pd2_q <= pd1_q;
    end
  end

  // NRZ data is delayed by the same two stages as the write clock so
  // that the capture edge meets the word that went with it.
  logic [NRZ_W-1:0] nrz1_q;
  logic [NRZ_W-1:0] nrz2_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nrz1_q <= '0;
      nrz2_q <= '0;
    end else begin
      nrz1_q <= nrz_write_in;
      nrz2_q <= nrz1_q;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [7:0] cor_q;
  logic [7:0] ctr_q;
  logic [7:0] pdr_q;
  logic [7:0] status;
  rcc_pkg::rcc_rclk_t rc_q;
  rcc_pkg::rcc_rclk_t rc_d;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cor_q <= rcc_pkg::COR_RESET;
      ctr_q <= rcc_pkg::CTR_RESET;
      pdr_q <= rcc_pkg::PDR_RESET;
    end else if (reg_wr) begin
      if (reg_addr == rcc_pkg::COR_ADDR) begin
        cor_q <= reg_wdata;
      end else if (reg_addr == rcc_pkg::CTR_ADDR) begin
        ctr_q <= reg_wdata;
      end else if (reg_addr == rcc_pkg::PDR_ADDR) begin
        pdr_q <= reg_wdata;
      end
    end
  end
  assign status = {rc_q, servo_mode, write_mode, read_mode, sleep_active};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == rcc_pkg::COR_ADDR) begin
        reg_rdata <= cor_q;
      end else if (reg_addr == rcc_pkg::CTR_ADDR) begin
        reg_rdata <= ctr_q;
      end else if (reg_addr == rcc_pkg::PDR_ADDR) begin
        reg_rdata <= pdr_q;
      end else if (reg_addr == rcc_pkg::STATUS_ADDR) begin
        reg_rdata <= status;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Mode decoding
  // ----------------------------------------------------------------
  logic awake;
  logic rg_prev_q;
  assign awake = pd2_q;
  assign sleep_active = !awake;
  assign section_power_on = awake ? ~pdr_q : 8'h00;
  assign low_impedance_on = awake & lz_s;
  assign fast_decay_on = awake & fr_s;
  assign agc_pump_on = awake & hold_s;
  assign equalizer_adapt_on = awake & !eq_s;
  assign read_mode = awake & rg_s;
  assign pll_ref_read_data = read_mode;
  assign write_mode = awake & (wg_s == cor_q[rcc_pkg::COR_WGP_BIT]);
  assign servo_mode = awake & sg_s;
  assign servo_agc_integrator = sg_s;
  assign data_agc_integrator = !sg_s;
  assign separator_clock_bypass = cor_q[rcc_pkg::COR_BYPASS_BIT];
  assign separator_clk_out = separator_clock_bypass ?
                             reference_frequency_in : separator_vco_in;
  assign backend_data_out = ctr_q[rcc_pkg::CTR_VIT_BIT] ?
                            viterbi_test_data_in : detector_data_in;
  assign write_flop_in = !dw_s ? direct_write_in : encoder_write_bit;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rg_prev_q <= 1'b0;
    end else begin
      rg_prev_q <= read_mode;
    end
  end
  assign read_start = read_mode & !rg_prev_q;

  // ----------------------------------------------------------------
  // NRZ write capture
  // ----------------------------------------------------------------
  // Nibble mode takes the low half-bus twice, upper nibble first.
  localparam int HW = NRZ_W / 2;
  logic             wclk_prev_q;
  logic             wclk_rise;
  logic             half_q;
  logic [HW-1:0]    hi_nib_q;
  assign wclk_rise = wclk_s & !wclk_prev_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wclk_prev_q      <= rcc_pkg::PIN_IDLE;
      half_q           <= 1'b0;
      hi_nib_q         <= '0;
      write_word       <= '0;
      write_word_valid <= 1'b0;
    end else begin
      wclk_prev_q      <= wclk_s;
      write_word_valid <= 1'b0;
      if (!write_mode) begin
        half_q <= 1'b0;
      end else if (wclk_rise) begin
        if (!cor_q[rcc_pkg::COR_NIBBLE_BIT]) begin
          write_word       <= nrz2_q;
          write_word_valid <= 1'b1;
        end else if (!half_q) begin
          hi_nib_q <= nrz2_q[HW-1:0];
          half_q   <= 1'b1;
        end else begin
          write_word       <= {hi_nib_q, nrz2_q[HW-1:0]};
          write_word_valid <= 1'b1;
          half_q           <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read reference clock source
  // ----------------------------------------------------------------
  // The output is parked low while switching and the new source is
  // joined only at one of its low phases, so no runt pulse appears.
  always_comb begin
    rc_d = rc_q;
    case (rc_q)
      rcc_pkg::RC_TBG: begin
        if (read_start) begin
          rc_d = rcc_pkg::RC_WAIT;
        end
      end
      rcc_pkg::RC_WAIT: begin
        if (!read_mode) begin
          rc_d = rcc_pkg::RC_TBG;
        end else if (sync_field_found && !rclk_out) begin
          rc_d = rcc_pkg::RC_SWITCH;
        end
      end
      rcc_pkg::RC_SWITCH: begin
        if (read_mode && !separator_vco_in) begin
          rc_d = rcc_pkg::RC_VCO;
        end else if (!read_mode && !time_base_in) begin
          rc_d = rcc_pkg::RC_TBG;
        end
      end
      rcc_pkg::RC_VCO: begin
        if (!read_mode && !rclk_out) begin
          rc_d = rcc_pkg::RC_SWITCH;
        end
      end
      default: begin
        rc_d = rcc_pkg::RC_TBG;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rc_q <= rcc_pkg::RC_TBG;
    end else begin
      rc_q <= rc_d;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rclk_out <= 1'b0;
    end else if (rc_d == rcc_pkg::RC_VCO) begin
      rclk_out <= separator_vco_in;
    end else if (rc_d == rcc_pkg::RC_SWITCH) begin
      rclk_out <= 1'b0;
    end else begin
      rclk_out <= time_base_in;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_read_rise;
    !read_mode ##1 read_mode;
  endsequence
  sequence s_sync_seen;
    rc_q == rcc_pkg::RC_WAIT && sync_field_found && !rclk_out && read_mode;
  endsequence

  chk_sync_two_stage: assert property (@(posedge clk) disable iff (!rst_b)
    awake && $rose(read_gate) ##1 read_gate ##1 read_gate
    |-> read_mode)
    else $error("read gate not seen two cycles after its rise");
  chk_rclk_stays_tbg: assert property (@(posedge clk) disable iff (!rst_b)
    s_read_rise ##0 rc_q == rcc_pkg::RC_TBG |=> rc_q == rcc_pkg::RC_WAIT)
    else $error("read clock left time base before sync");
  chk_rclk_to_vco: assert property (@(posedge clk) disable iff (!rst_b)
    s_sync_seen |=> rc_q == rcc_pkg::RC_SWITCH
    ##[1:1000] (rc_q == rcc_pkg::RC_VCO || !read_mode))
    else $error("read clock did not start switching after sync");
  chk_switch_low: assert property (@(posedge clk) disable iff (!rst_b)
    rc_q == rcc_pkg::RC_SWITCH |-> !rclk_out)
    else $error("read clock not parked low while switching");
  chk_read_start: assert property (@(posedge clk) disable iff (!rst_b)
    read_start |-> read_mode && !$past(read_mode) && pll_ref_read_data)
    else $error("read start without read gate rise");
  chk_sleep_gates: assert property (@(posedge clk) disable iff (!rst_b)
    sleep_active |-> section_power_on == 8'h00 && !agc_pump_on
    && !write_mode && !read_mode)
    else $error("circuitry active while asleep");
  chk_power_reg: assert property (@(posedge clk) disable iff (!rst_b)
    awake && reg_wr && reg_addr == rcc_pkg::PDR_ADDR ##1 awake
    |-> section_power_on == ~$past(reg_wdata))
    else $error("section power does not follow power register");
  chk_write_pol: assert property (@(posedge clk) disable iff (!rst_b)
    awake |-> write_mode == (wg_s == cor_q[rcc_pkg::COR_WGP_BIT]))
    else $error("write mode ignores gate polarity");
  chk_integrator: assert property (@(posedge clk) disable iff (!rst_b)
    servo_agc_integrator != data_agc_integrator
    && servo_agc_integrator == sync2_q[6])
    else $error("AGC integrators not exclusive");
  chk_byte_capture: assert property (@(posedge clk) disable iff (!rst_b)
    write_mode && wclk_rise && !cor_q[rcc_pkg::COR_NIBBLE_BIT]
    |=> write_word_valid && write_word == $past(nrz2_q))
    else $error("byte not captured on write clock rise");
  chk_bypass_mux: assert property (@(posedge clk) disable iff (!rst_b)
    separator_clock_bypass |-> separator_clk_out == reference_frequency_in)
    else $error("separator not fed from reference");
  chk_vit_path: assert property (@(posedge clk) disable iff (!rst_b)
    !ctr_q[rcc_pkg::CTR_VIT_BIT] |-> backend_data_out == detector_data_in)
    else $error("test data leaked into back end");
  chk_eq_freeze: assert property (@(posedge clk) disable iff (!rst_b)
    awake && equalizer_freeze [*3] |-> !equalizer_adapt_on)
    else $error("equalizer adapting during freeze");
  chk_reset_idle: assert property (@(posedge clk)
    $rose(rst_b) |-> sync2_q == {NS{1'b1}})
    else $error("pins not idle high after reset");
endmodule
`default_nettype wire

// ===== bench/rcc_host_model.sv
// Partner model: disk controller side of the sleep and NRZ write pins.
// Assumes the bench calls its tasks and that it shares the block clock.
`timescale 1ns/10ps
`default_nettype none
module rcc_host_model #(
  parameter int NRZ_W = 8
) (
  input  wire logic             clk,
  output logic                  sleep_request_n,
  output logic                  write_clock,
  output logic      [NRZ_W-1:0] nrz_write_in
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // The sleep pin has no pull-up, so it is always driven to a level.
  initial begin
    sleep_request_n = 1'b0;
    write_clock     = 1'b0;
    nrz_write_in    = {NRZ_W{1'b0}};
  end

  task automatic set_awake(input logic awake);
    @(posedge clk);
    sleep_request_n <= awake;
  endtask

  // Data settles a cycle before the clock rises and holds while it is
  // high; afterwards the bus shows the inverse so a late sample fails.
  task automatic send_word(input logic [NRZ_W-1:0] word);
    @(posedge clk);
    nrz_write_in <= word;
    @(posedge clk);
    write_clock <= 1'b1;
    repeat (3) @(posedge clk);
    write_clock  <= 1'b0;
    nrz_write_in <= ~word;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== bench/rcc_core_bench.sv
// Self-checking bench for the read-channel control-input block.
// Assumes the design checks its own timing; this bench checks levels.
`timescale 1ns/10ps
`default_nettype none
module rcc_core_bench;
  localparam int NRZ_W = 8;
  typedef struct packed {
    logic [7:0] pins;
    logic [9:0] outs;
  } rcc_row_t;
  logic             clk, rst_b, reg_wr, reg_rd;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata, section_power_on;
  logic             low_impedance_ctl, fast_recovery_ctl, agc_hold_n;
  logic             equalizer_freeze, read_gate, write_gate, servo_gate;
  logic             direct_write2_enable_n, write_clock, sleep_request_n;
  logic [NRZ_W-1:0] nrz_write_in, write_word;
  logic             reference_frequency_in, separator_vco_in, time_base_in;
  logic             sync_field_found, viterbi_test_data_in;
  logic             detector_data_in, direct_write_in, encoder_write_bit;
  logic             low_impedance_on, fast_decay_on, sleep_active;
  logic             agc_pump_on, equalizer_adapt_on, separator_clock_bypass;
  logic             separator_clk_out, pll_ref_read_data, read_mode;
  logic             read_start, write_mode, servo_mode, servo_agc_integrator;
  logic             data_agc_integrator, backend_data_out, write_flop_in;
  logic             rclk_out, write_word_valid;
  int               num_errors, samples_checked, k;
  rcc_row_t         rows [4] = '{'{8'h00, 10'h043}, '{8'hff, 10'h3bc},
                                 '{8'ha5, 10'h2d2}, '{8'h5a, 10'h12d}};

  rcc_core #(.NRZ_W(NRZ_W)) u_dut (.clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .low_impedance_ctl, .fast_recovery_ctl,
    .sleep_request_n, .agc_hold_n, .equalizer_freeze, .read_gate,
    .write_gate, .servo_gate, .direct_write2_enable_n, .write_clock,
    .nrz_write_in, .reference_frequency_in, .separator_vco_in,
    .time_base_in, .sync_field_found, .viterbi_test_data_in,
    .detector_data_in, .direct_write_in, .encoder_write_bit,
    .low_impedance_on, .fast_decay_on, .sleep_active, .section_power_on,
    .agc_pump_on, .equalizer_adapt_on, .separator_clock_bypass,
    .separator_clk_out, .pll_ref_read_data, .read_mode, .read_start,
    .write_mode, .servo_mode, .servo_agc_integrator, .data_agc_integrator,
    .backend_data_out, .write_flop_in, .rclk_out, .write_word,
    .write_word_valid);
  rcc_host_model #(.NRZ_W(NRZ_W)) u_host (.clk, .sleep_request_n,
    .write_clock, .nrz_write_in);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [9:0] got, input logic [9:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic drive_pins(input logic [7:0] v);
    @(posedge clk);
    {low_impedance_ctl, fast_recovery_ctl, agc_hold_n, equalizer_freeze,
     read_gate, write_gate, servo_gate, direct_write2_enable_n} <= v;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp, "register read");
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h0;
    {low_impedance_ctl, fast_recovery_ctl, agc_hold_n, equalizer_freeze,
     read_gate, write_gate, servo_gate, direct_write2_enable_n} = 8'h00;
    {reference_frequency_in, separator_vco_in, time_base_in} = 3'h0;
    {sync_field_found, viterbi_test_data_in, detector_data_in} = 3'h0;
    direct_write_in   = 1'b1;
    encoder_write_bit = 1'b0;
    @(posedge clk);
    #1;
    check(servo_agc_integrator, 10'h1, "open servo gate");
    check(sleep_active, 10'h1, "reset sleep");
    @(posedge clk);
    rst_b <= 1'b1;
    reg_read(rcc_pkg::COR_ADDR, rcc_pkg::COR_RESET);
    reg_read(rcc_pkg::CTR_ADDR, rcc_pkg::CTR_RESET);
    reg_read(rcc_pkg::PDR_ADDR, rcc_pkg::PDR_RESET);
    reg_read(8'h10, 8'h00);
    u_host.set_awake(1'b1);
    step(4);
    check(sleep_active, 10'h0, "wake");
    for (int i = 0; i < 4; i++) begin
      drive_pins(rows[i].pins);
      step(3);
      check({low_impedance_on, fast_decay_on, agc_pump_on,
             equalizer_adapt_on, read_mode, write_mode, servo_mode,
             servo_agc_integrator, data_agc_integrator, write_flop_in},
            rows[i].outs,
            "pin decode");
      check(pll_ref_read_data, rows[i].pins[3], "pll ref");
    end
    drive_pins(8'h80);
    time_base_in <= 1'b1;
    step(1);
    check(low_impedance_on, 10'h0, "first stage only");
    step(1);
    check(low_impedance_on, 10'h1, "second stage");
    step(2);
    check(rclk_out, 10'h1, "time base clock");
    @(posedge clk);
    time_base_in <= 1'b0;
    step(2);
    check(rclk_out, 10'h0, "time base low");
    drive_pins(8'h88);
    separator_vco_in <= 1'b1;
    step(2);
    check(read_start, 10'h1, "read start");
    step(1);
    check(read_start, 10'h0, "read start one cycle");
    step(6);
    check(rclk_out, 10'h0, "no switch before sync");
    @(posedge clk);
    sync_field_found <= 1'b1;
    separator_vco_in <= 1'b0;
    step(6);
    @(posedge clk);
    separator_vco_in <= 1'b1;
    step(2);
    check(rclk_out, 10'h1, "vco clock after sync");
    // Status: read clock on the VCO, read mode only.
    reg_read(rcc_pkg::STATUS_ADDR, 8'h82);
    reg_write(rcc_pkg::COR_ADDR, 8'h09);
    reference_frequency_in <= 1'b1;
    separator_vco_in       <= 1'b0;
    step(2);
    check(separator_clock_bypass, 10'h1, "bypass bit");
    check(separator_clk_out, 10'h1, "reference routed");
    reg_write(rcc_pkg::COR_ADDR, 8'h00);
    viterbi_test_data_in <= 1'b1;
    drive_pins(8'h80);
    sync_field_found <= 1'b0;
    step(3);
    check(separator_clk_out, 10'h0, "vco routed");
    check(write_mode, 10'h1, "low active write gate");
    check(backend_data_out, 10'h0, "detector path");
    reg_write(rcc_pkg::CTR_ADDR, 8'h01);
    reg_write(rcc_pkg::PDR_ADDR, 8'h0f);
    reg_write(rcc_pkg::COR_ADDR, 8'h01);
    step(2);
    check(backend_data_out, 10'h1, "test path");
    check(section_power_on, 10'h0f0, "section power");
    check(write_mode, 10'h0, "inactive write gate");
    drive_pins(8'h84);
    step(3);
    fork
      u_host.send_word(8'h3c);
      for (k = 0; k < 12 && write_word_valid !== 1'b1; k++) step(1);
    join
    if (k == 12) begin
      num_errors++;
      $display("[ERR] %0t write word never valid", $time);
      stop_test();
    end
    check(write_word, 10'h03c, "captured word");
    // Nibble mode pairs two rises into one word, upper nibble first.
    reg_write(rcc_pkg::COR_ADDR, 8'h03);
    fork
      begin
        u_host.send_word(8'h0a);
        u_host.send_word(8'h05);
      end
      for (k = 0; k < 24 && write_word_valid !== 1'b1; k++) step(1);
    join
    if (k == 24) begin
      num_errors++;
      $display("[ERR] %0t nibble word never valid", $time);
      stop_test();
    end
    check(write_word, 10'h0a5, "nibble pair");
    drive_pins(8'hff);
    u_host.set_awake(1'b0);
    step(4);
    check(sleep_active, 10'h1, "sleep");
    check(low_impedance_on, 10'h0, "asleep lowz");
    check(section_power_on, 10'h0, "asleep sections");
    check(servo_agc_integrator, 10'h1, "asleep integrator");
    // A second reset in mid-run must restore the register defaults.
    @(posedge clk);
    rst_b <= 1'b0;
    step(2);
    check(write_word, 10'h000, "reset clears word");
    check(servo_agc_integrator, 10'h1, "reset pins idle");
    @(posedge clk);
    rst_b <= 1'b1;
    reg_read(rcc_pkg::COR_ADDR, rcc_pkg::COR_RESET);
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("[ERR] %0t run limit reached", $time);
    stop_test();
  end
endmodule
`default_nettype wire
